// *** hdl/flash_powerup_mode_select.sv ***
`default_nettype none
module flash_powerup_mode_select
  import pwrup_pkg::*;
#(
  parameter int unsigned SEL_WAIT_CYC   = SEL_AFTER_SUPPLY_CYC,
  parameter int unsigned WRITE_WAIT_CYC = WRITE_AFTER_PU_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  // Internal power-on reset, high while supply below threshold
  input  wire logic       i_por_active,
  // Link pins from the host
  input  wire link_in_t   i_link,
  // Instruction end from the command decoder (same clock)
  input  wire logic       i_instr_done,
  // Data lines drive requested by the read path (same clock)
  input  wire data_out_t  i_data_req,
  // Mode and state reporting
  output logic            o_mode3,
  output logic            o_instr_start,
  output logic            o_standby,
  output logic            o_read_allowed,
  output logic            o_write_allowed,
  // Data line drive
  output data_out_t       o_data
);

  // Synchronisers for the link pins; stage one feeds stage two only
  link_in_t   sync1_r;
  link_in_t   sync2_r;
  // Previous select level, for edge finding
  logic       sel_prev_r;
  // Power state
  pwr_state_t state_r;
  // Counter since the reset threshold was crossed
  logic [PU_CNT_W-1:0] pu_cnt_r;
  // Falling edge of select, seen on synchronised levels
  logic       sel_fall;

  // Two flip-flops per pin; select idles high so reset to inactive
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync1_r <= '{sel_n: 1'b1, clk: 1'b1};
      sync2_r <= '{sel_n: 1'b1, clk: 1'b1};
    end else begin
      sync1_r <= i_link;
      sync2_r <= sync1_r;
    end
  end

  // Edge history of select
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sel_prev_r <= 1'b1;
    end else begin
      sel_prev_r <= sync2_r.sel_n;
    end
  end

  // A fall only counts outside power-on reset
  // A fall held through power-on reset is lost, not queued for later
  assign sel_fall = sel_prev_r && !sync2_r.sel_n && !i_por_active;

  // Power-up timer; restarts whenever the supply drops below threshold
  // Saturates at the write wait so it never wraps and reopens a window
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_por_active) begin
      pu_cnt_r <= '0;
    end else if (pu_cnt_r < PU_CNT_W'(WRITE_WAIT_CYC)) begin
      pu_cnt_r <= pu_cnt_r + PU_CNT_W'(1);
    end
  end

  // Read and write windows; host is expected to respect them
  // Informational only: the device does not block an early select
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_por_active) begin
      o_read_allowed  <= 1'b0;
      o_write_allowed <= 1'b0;
    end else begin
      o_read_allowed  <= pu_cnt_r >= PU_CNT_W'(SEL_WAIT_CYC);
      o_write_allowed <= pu_cnt_r >= PU_CNT_W'(WRITE_WAIT_CYC);
    end
  end

  // Power state machine
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= ST_POR;
    end else if (i_por_active) begin
      state_r <= ST_POR;
    end else begin
      unique case (state_r)
        // Power-up done: go to standby, never straight to active
        ST_POR: begin
          state_r <= ST_STANDBY;
        end
        ST_STANDBY: begin
          if (sel_fall) begin
            state_r <= ST_ACTIVE;
          end
        end
        // Deselect or decoder end returns to standby
        ST_ACTIVE: begin
          if (sync2_r.sel_n || i_instr_done) begin
            state_r <= ST_STANDBY;
          end
        end
        // Unused code: fall back to the power-up state
        default: begin
          state_r <= ST_POR;
        end
      endcase
    end
  end

  // Mode choice: idle clock level at each select fall
  // Limitation: a clock edge within two cycles of the fall may pick the wrong mode
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_por_active) begin
      o_mode3 <= MODE3_RESET;
    end else if (sel_fall) begin
      o_mode3 <= sync2_r.clk;
    end
  end

  // One-cycle start pulse for the command decoder
  // Gated by standby so a fall during an instruction is refused
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_instr_start <= 1'b0;
    end else begin
      o_instr_start <= sel_fall && (state_r == ST_STANDBY);
    end
  end

  // Standby flag
  // Cleared under power-on reset so standby shows only once power is good
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_standby <= 1'b0;
    end else begin
      o_standby <= (state_r == ST_STANDBY) && !i_por_active;
    end
  end

  // Output drive only in an active instruction; tri-state otherwise
  // The request passes only while the synchronised select is still low
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_por_active) begin
      o_data <= '0;
    end else if (state_r == ST_ACTIVE && !sync2_r.sel_n) begin
      o_data <= i_data_req;
    end else begin
      o_data <= '0;
    end
  end

  // Outputs stay released for the cycle after reset
  after_reset_tristate_a : assert property (@(posedge i_clk_sys)
    $fell(i_reset) |-> o_data.ser_oe == 1'b0 && o_data.par_oe == 8'h00)
    else $error("data lines driven right after reset");

  reset_mode3_a : assert property (@(posedge i_clk_sys)
    $past(i_reset) |-> o_mode3)
    else $error("mode not 3 after reset");

  mode_sample_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    sel_fall && !i_por_active |=> o_mode3 == $past(sync2_r.clk))
    else $error("mode does not follow idle clock");

  start_needs_fall_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_instr_start |-> $past(sel_fall))
    else $error("start without select fall");

  por_ignores_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_por_active [*2] |=> !o_instr_start && state_r == ST_POR)
    else $error("command taken during power-on reset");

  standby_entry_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r == ST_POR && !i_por_active |=> state_r == ST_STANDBY ##1 o_standby || i_por_active)
    else $error("no standby after power-up");

  // Power-on reset keeps the lines released and restores mode 3
  por_tristate_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_por_active |=> o_data == '0 && o_mode3)
    else $error("lines driven or mode lost under power-on reset");

  // Nothing drives the lines outside an active instruction
  idle_released_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    state_r != ST_ACTIVE |=> o_data == '0)
    else $error("lines driven outside an instruction");

  // Start is a single pulse; a held select never restarts
  start_single_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_instr_start |=> !o_instr_start)
    else $error("start pulse longer than one cycle");

  // Mode holds between select falls outside power-on reset
  mode_hold_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !sel_fall && !i_por_active |=> $stable(o_mode3))
    else $error("mode changed without select fall");

  // Standby is never reported while power-on reset holds
  por_no_standby_a : assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_por_active |=> !o_standby)
    else $error("standby reported under power-on reset");

  // Main scenarios
  cov_mode0_c : cover property (@(posedge i_clk_sys) sel_fall && !sync2_r.clk);
  cov_mode3_c : cover property (@(posedge i_clk_sys) sel_fall && sync2_r.clk);
  cov_start_c : cover property (@(posedge i_clk_sys) o_instr_start);
  cov_done_c  : cover property (@(posedge i_clk_sys) state_r == ST_ACTIVE && i_instr_done);
  cov_por_c   : cover property (@(posedge i_clk_sys) i_por_active && !sync2_r.sel_n);

endmodule
`default_nettype wire

// *** hdl/pwrup_pkg.sv ***
`default_nettype none
package pwrup_pkg;
  // Clock period of the sampling clock, in nanoseconds
  localparam int unsigned CLK_PERIOD_NS       = 10;
  // Least wait from supply good to select low, in microseconds
  localparam int unsigned SEL_AFTER_SUPPLY_US = 50;
  // Longest wait from reset threshold to write allowed, in milliseconds
  localparam int unsigned WRITE_AFTER_PU_MS   = 20;
  // Cycle counts derived from the times (least rounds up, longest rounds down)
  localparam int unsigned SEL_AFTER_SUPPLY_CYC =
    (SEL_AFTER_SUPPLY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_AFTER_PU_CYC =
    (WRITE_AFTER_PU_MS * 1000000) / CLK_PERIOD_NS;
  // Width of the power-up counter
  localparam int unsigned PU_CNT_W            = 22;
  // Clocking mode after reset
  localparam logic        MODE3_RESET         = 1'b1;

  // Device power states
  typedef enum logic [1:0] {
    ST_POR,
    ST_STANDBY,
    ST_ACTIVE
  } pwr_state_t;

  // Link pins as seen by the device
  typedef struct packed {
    logic       sel_n;
    logic       clk;
  } link_in_t;

  // Output drive of the serial and parallel data lines
  typedef struct packed {
    logic [7:0] par_data;
    logic [7:0] par_oe;
    logic       ser_data;
    logic       ser_oe;
  } data_out_t;
endpackage
`default_nettype wire

// *** verification/flash_powerup_mode_select_tb_top.sv ***
`default_nettype none
module flash_powerup_mode_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwrup_pkg::*;
  logic      clk = 1'b0, rst = 1'b1, por = 1'b0, frame = 1'b0, idle_hi = 1'b1, done = 1'b0;
  logic      mode3, start, stby, rd_ok, wr_ok;
  data_out_t req = 18'h2A5FF, dout;
  link_in_t  link;
  int        error_cnt = 0, samples_checked = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  link_host host (.i_frame(frame), .i_idle_hi(idle_hi), .o_link(link));
  flash_powerup_mode_select #(.SEL_WAIT_CYC(20), .WRITE_WAIT_CYC(100)) dut (
    .i_clk_sys(clk), .i_reset(rst), .i_por_active(por), .i_link(link),
    .i_instr_done(done), .i_data_req(req), .o_mode3(mode3), .o_instr_start(start),
    .o_standby(stby), .o_read_allowed(rd_ok), .o_write_allowed(wr_ok), .o_data(dout));
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Frame with a given idle clock level; optionally end it by done
  task automatic t_frame(input logic hi, input logic end_by_done);
    int k;
    k = 0;
    idle_hi = hi;
    ticks(2);
    frame = 1'b1;
    while (start !== 1'b1 && k < 10) begin
      ticks(1);
      k++;
    end
    chk("start", 18'h1, start);
    chk("mode3", {17'h0, hi}, mode3);
    ticks(2);
    chk("data", req, dout);
    chk("active standby", 18'h0, stby);
    if (end_by_done) begin
      done = 1'b1;
      ticks(1);
      done = 1'b0;
      repeat (6) begin
        ticks(1);
        chk("restart", 18'h0, start);
      end
      chk("standby", 18'h1, stby);
      chk("data after done", 18'h0, dout);
    end
    frame = 1'b0;
    ticks(6);
    chk("data idle", 18'h0, dout);
    $display("frame test done");
  endtask
  // Reset held for n cycles: mode 3, lines released, then standby
  task automatic t_reset(input int n);
    rst = 1'b1;
    ticks(n);
    chk("reset mode3", 18'h1, mode3);
    chk("reset data", 18'h0, dout);
    rst = 1'b0;
    ticks(4);
    chk("standby", 18'h1, stby);
    chk("reset start", 18'h0, start);
    $display("reset test done");
  endtask
  // Falls under power-on reset are ignored; then the power-up waits
  task automatic t_por;
    por = 1'b1;
    idle_hi = 1'b0;
    frame = 1'b1;
    repeat (12) begin
      ticks(1);
      chk("por start", 18'h0, start);
    end
    chk("por mode3", 18'h1, mode3);
    chk("por data", 18'h0, dout);
    chk("por standby", 18'h0, stby);
    frame = 1'b0;
    ticks(4);
    por = 1'b0;
    ticks(12);
    chk("read early", 18'h0, rd_ok);
    ticks(12);
    chk("read late", 18'h1, rd_ok);
    chk("write early", 18'h0, wr_ok);
    ticks(80);
    chk("write late", 18'h1, wr_ok);
    $display("power-on test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset, read wait, frames, power-on reset, mid-run reset
  initial begin
    t_reset(6);
    while (rd_ok !== 1'b1) begin
      ticks(1);
    end
    t_frame(1'b0, 1'b0);
    t_frame(1'b1, 1'b1);
    t_frame(1'b0, 1'b0);
    t_por();
    t_frame(1'b0, 1'b0);
    t_reset(2);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** verification/link_host.sv ***
`default_nettype none
module link_host
  import pwrup_pkg::*;
(
  // Frame request and idle clock level
  input  wire logic     i_frame,
  input  wire logic     i_idle_hi,
  // Pins to the device
  output var link_in_t  o_link
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;  // Phase of the running link clock
  // Select rests high between frames so no stray fall starts anything
  assign o_link.sel_n = ~i_frame;
  // Clock stands at its idle level outside frames
  assign o_link.clk = i_idle_hi ^ (i_frame & tog);
  // 160 ns link clock, first edge half a period after select falls
  always begin
    tog = 1'b0;
    wait (i_frame);
    #80;
    while (i_frame) begin
      tog = ~tog;
      #80;
    end
  end
endmodule
`default_nettype wire
